/* File: bcc_params.svh */
// Constants for the branch/call/clear execution block
`ifndef BCC_PARAMS_SVH
`define BCC_PARAMS_SVH
`define BCC_OP_BRANCH_OVF   8'hE4
`define BCC_OP_BRANCH_ZERO  8'hE0
`define BCC_OP_CALL_HI      7'h76
`define BCC_OP_CLEAR_HI     7'h35
`define BCC_OP_WDT_CLEAR    16'h0004
`define BCC_CALL_PUSH_OFS   21'h000004
`define BCC_BRANCH_OFS      21'h000002
`define BCC_ACCESS_LIMIT    8'h5F
`define BCC_ACCESS_SPLIT    8'h60
`define BCC_ZERO_BYTE       8'h00
`define BCC_PC_RESET        21'h000000
`define BCC_STATUS_Z_BIT    2
`define BCC_STATUS_OV_BIT   3
`define BCC_Q_LAST          2'h3
`endif

/* File: bcc_pkg.sv */
// Types shared by the execution block
package bcc_pkg;
    typedef enum logic [2:0] {
        BCC_I_NONE,
        BCC_I_BRANCH_OVF,
        BCC_I_BRANCH_ZERO,
        BCC_I_CALL,
        BCC_I_CLEAR,
        BCC_I_WDT_CLEAR
    } bcc_instr_e;
    typedef struct packed {
        bcc_instr_e kind;
        logic [7:0] literal;
        logic       flag_bit;
    } bcc_decoded_s;
endpackage

/* File: bcc_dec_if.sv */
// Interface carrying decoded instruction between decoder and core
`timescale 1ns/100ps
`default_nettype none
interface bcc_dec_if;
    import bcc_pkg::*;
    logic [15:0]  word;
    bcc_decoded_s dec;
    modport decoder (input word, output dec);
    modport core (output word, input dec);
endinterface
`default_nettype wire

/* File: bcc_decoder.sv */
// Opcode decoder for the branch, call, clear and watchdog-clear group
`timescale 1ns/100ps
`default_nettype none
`include "bcc_params.svh"
module bcc_decoder
    import bcc_pkg::*;
(
    bcc_dec_if.decoder dif
);
    always_comb begin
        dif.dec.literal  = dif.word[7:0];
        dif.dec.flag_bit = dif.word[8];
        if (dif.word[15:8] == `BCC_OP_BRANCH_OVF) begin
            dif.dec.kind = BCC_I_BRANCH_OVF;
        end else if (dif.word[15:8] == `BCC_OP_BRANCH_ZERO) begin
            dif.dec.kind = BCC_I_BRANCH_ZERO;
        end else if (dif.word[15:9] == `BCC_OP_CALL_HI) begin
            dif.dec.kind = BCC_I_CALL;
        end else if (dif.word[15:9] == `BCC_OP_CLEAR_HI) begin
            dif.dec.kind = BCC_I_CLEAR;
        end else if (dif.word == `BCC_OP_WDT_CLEAR) begin
            dif.dec.kind = BCC_I_WDT_CLEAR;
        end else begin
            dif.dec.kind = BCC_I_NONE;
        end
    end
endmodule
`default_nettype wire

/* File: bcc_phase.sv */
// Four-phase sequencer of the instruction cycle
`timescale 1ns/100ps
`default_nettype none
`include "bcc_params.svh"
module bcc_phase (
    input  wire logic       clk,
    input  wire logic       reset_n,
    output logic [1:0]      phase,
    output logic            last
);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end
    assign last = (phase == `BCC_Q_LAST);
endmodule
`default_nettype wire

/* File: bcc_exec.sv */
// Execution unit for branch, call, clear-register and watchdog-clear
//
// Functional notes
// - Overflow branch decoded from E4h upper byte.
// - Zero branch decoded from E0h upper byte.
// - Taken target is counter plus two plus 2n.
// - Branch one cycle untaken, two when taken.
// - Call pushes counter plus four to stack.
// - Shadow bit set copies working, status, bank.
// - Call target loads counter bits 20 to 1.
// - Low target from word one, high from two.
// - Call takes two cycles, second is idle.
// - Clear writes zero to register, sets zero.
// - Access bit picks access or selected bank.
// - Extended set, access bit clear, low address uses indexed mode.
// - Watchdog clear zeroes counter, sets both flags.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "bcc_params.svh"
module bcc_exec
    import bcc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [15:0] instr_word,
    input  wire logic [7:0]  working_reg,
    input  wire logic [7:0]  status_reg,
    input  wire logic [3:0]  bank_select_register,
    input  wire logic [11:0] index_base,
    input  wire logic        extended_enable,
    output logic [20:0]      pc,
    output logic [1:0]       phase,
    output logic             fetch_next,
    output logic             stack_push,
    output logic [20:0]      stack_top,
    output logic [7:0]       working_shadow,
    output logic [7:0]       status_shadow,
    output logic [3:0]       bank_select_shadow,
    output logic             mem_write,
    output logic [11:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    output logic             zero_set,
    output logic             watchdog_clear,
    output logic             timeout_flag_n,
    output logic             powerdown_flag_n,
    output logic             busy
);
    typedef enum logic [1:0] {BCC_S_EXEC, BCC_S_CALL_WAIT, BCC_S_IDLE_CYCLE} bcc_state_e;

    bcc_state_e   state;
    bcc_dec_if    dif ();
    logic         last;
    logic [1:0]   ph;
    logic [7:0]   call_low;
    logic [20:0]  branch_target;
    logic         overflow_flag;
    logic         zero_flag;
    logic         take;
    logic [11:0]  next_addr;
    logic [7:0]   lit;

    // Phase and launch strobes
    logic         is_exec;
    logic         q2_strobe;
    logic         q3_strobe;
    logic         q4_strobe;
    logic         call_first;
    logic         call_seen;
    logic         clear_first;
    logic         wdt_first;
    logic         shadow_first;

    // Addressing and sequencing
    logic [20:0]  branch_step;
    logic [11:0]  access_addr;
    logic [11:0]  indexed_addr;
    logic         use_indexed;
    logic [20:0]  next_pc;
    bcc_state_e   next_state;

    bcc_phase u_phase (
        .clk     (clk),
        .reset_n (reset_n),
        .phase   (ph),
        .last    (last)
    );

    bcc_decoder u_dec (
        .dif (dif)
    );

    assign dif.word      = instr_word;
    assign lit           = dif.dec.literal;
    assign overflow_flag = status_reg[`BCC_STATUS_OV_BIT];
    assign zero_flag     = status_reg[`BCC_STATUS_Z_BIT];

    // Offset sign-extended and doubled; counter still points at us, so two is added
    assign branch_step   = {{12{lit[7]}}, lit, 1'b0};
    assign branch_target = pc + `BCC_BRANCH_OFS + branch_step;

    always_comb begin
        take = 1'b0;
        unique case (dif.dec.kind)
            BCC_I_BRANCH_OVF: begin
                take = overflow_flag;
            end
            BCC_I_BRANCH_ZERO: begin
                take = zero_flag;
            end
            default: begin
                take = 1'b0;
            end
        endcase
    end

    // Indexed literal-offset only reaches the low 96 addresses
    assign use_indexed  = !dif.dec.flag_bit && extended_enable
                          && (lit <= `BCC_ACCESS_LIMIT);
    assign indexed_addr = index_base + {4'h0, lit};

    // Access bank: below 60h maps to bank 0, 60h and up to bank 15
    always_comb begin
        if (lit < `BCC_ACCESS_SPLIT) begin
            access_addr = {4'h0, lit};
        end else begin
            access_addr = {4'hF, lit};
        end
    end

    // Data address for the clear-register instruction
    always_comb begin
        if (use_indexed) begin
            next_addr = indexed_addr;
        end else if (!dif.dec.flag_bit) begin
            next_addr = access_addr;
        end else begin
            next_addr = {bank_select_register, lit};
        end
    end

    assign phase = ph;

    // Phase strobes; outputs registered on them land one phase later
    assign is_exec   = (state == BCC_S_EXEC);
    assign q2_strobe = (ph == 2'h1);
    assign q3_strobe = (ph == 2'h2);
    assign q4_strobe = last;

    // Work launched from the first word of each instruction
    assign call_first   = is_exec && (dif.dec.kind == BCC_I_CALL);
    assign clear_first  = is_exec && (dif.dec.kind == BCC_I_CLEAR);
    assign wdt_first    = is_exec && (dif.dec.kind == BCC_I_WDT_CLEAR);
    assign shadow_first = call_first && dif.dec.flag_bit;

    // Call remembered past Q3: in Q4 the bus carries the second word,
    // which decodes as none of ours
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            call_seen <= 1'b0;
        end else if (q4_strobe) begin
            call_seen <= 1'b0;
        end else if (call_first && q2_strobe) begin
            call_seen <= 1'b1;
        end
    end

    // Next sequencer state, applied at the end of Q4
    always_comb begin
        next_state = state;
        unique case (state)
            BCC_S_EXEC: begin
                if (call_seen) begin
                    next_state = BCC_S_IDLE_CYCLE;
                end else if (take) begin
                    next_state = BCC_S_IDLE_CYCLE;
                end
            end
            BCC_S_CALL_WAIT: begin
                next_state = BCC_S_EXEC;
            end
            BCC_S_IDLE_CYCLE: begin
                next_state = BCC_S_EXEC;
            end
            default: begin
                next_state = BCC_S_EXEC;
            end
        endcase
    end

    // Next counter; only the Q4 edge of an executing cycle applies it
    always_comb begin
        if (call_seen) begin
            // Second word is present on instr_word in phase four
            next_pc = {instr_word[11:0], call_low, 1'b0};
        end else if (take) begin
            next_pc = branch_target;
        end else begin
            next_pc = pc + `BCC_BRANCH_OFS;
        end
    end

    // Instruction sequencer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= BCC_S_EXEC;
        end else if (q4_strobe) begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
        end else begin
            busy <= (state != BCC_S_EXEC);
        end
    end

    // Low call literal latched in phase two of the first word
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            call_low <= `BCC_ZERO_BYTE;
        end else if (state == BCC_S_EXEC && ph == 2'h1 && dif.dec.kind == BCC_I_CALL) begin
            call_low <= lit;
        end
    end

    // Program counter: written only in the fourth phase
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pc <= `BCC_PC_RESET;
        end else if (q4_strobe && is_exec) begin
            pc <= next_pc;
        end
    end

    // Fetch handshake toward instruction memory
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fetch_next <= 1'b0;
        end else begin
            fetch_next <= (ph == 2'h2) && (state == BCC_S_EXEC) && (dif.dec.kind == BCC_I_CALL);
        end
    end

    // Return-stack push pulse, raised for Q4 of the call's first cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stack_push <= 1'b0;
        end else begin
            stack_push <= call_first && q3_strobe;
        end
    end

    // Return address: counter plus four, past the second call word
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stack_top <= `BCC_PC_RESET;
        end else if (call_first && q3_strobe) begin
            stack_top <= pc + `BCC_CALL_PUSH_OFS;
        end
    end

    // Shadow copy on a fast call
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            working_shadow     <= `BCC_ZERO_BYTE;
            status_shadow      <= `BCC_ZERO_BYTE;
            bank_select_shadow <= 4'h0;
        end else if (shadow_first && q3_strobe) begin
            working_shadow     <= working_reg;
            status_shadow      <= status_reg;
            bank_select_shadow <= bank_select_register;
        end
    end

    // Clear-register pulses in phase four; status left alone elsewhere
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_write <= 1'b0;
            zero_set  <= 1'b0;
        end else begin
            mem_write <= clear_first && q3_strobe;
            zero_set  <= clear_first && q3_strobe;
        end
    end

    // Address held after the write so the memory side may sample late
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_addr <= 12'h000;
        end else if (clear_first && q3_strobe) begin
            mem_addr <= next_addr;
        end
    end

    // Only the clear-register instruction writes data, always zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_wdata <= `BCC_ZERO_BYTE;
        end else if (clear_first && q3_strobe) begin
            mem_wdata <= `BCC_ZERO_BYTE;
        end
    end

    // Watchdog-clear pulse toward the watchdog counter and postscaler
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            watchdog_clear <= 1'b0;
        end else begin
            watchdog_clear <= wdt_first && q3_strobe;
        end
    end

    // Flags only ever set here; clearing them belongs to sleep logic
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timeout_flag_n   <= 1'b1;
            powerdown_flag_n <= 1'b1;
        end else if (wdt_first && q3_strobe) begin
            timeout_flag_n   <= 1'b1;
            powerdown_flag_n <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: bcc_exec_checker.sv */
// Port-level assertions for the execution unit
`timescale 1ns/100ps
`default_nettype none
module bcc_exec_checker (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [15:0] instr_word,
    input wire logic [7:0]  status_reg,
    input wire logic [20:0] pc,
    input wire logic [1:0]  phase,
    input wire logic        stack_push,
    input wire logic [20:0] stack_top,
    input wire logic [7:0]  working_shadow,
    input wire logic        mem_write,
    input wire logic [7:0]  mem_wdata,
    input wire logic        zero_set,
    input wire logic        watchdog_clear,
    input wire logic        timeout_flag_n,
    input wire logic        powerdown_flag_n,
    input wire logic        busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Branch outcomes worked out here, so $past sees whole vectors
    logic [20:0] jump_to;
    logic [20:0] ovf_next;
    logic [20:0] zero_next;
    assign jump_to   = pc + 21'h000002 + {{12{instr_word[7]}}, instr_word[7:0], 1'b0};
    assign ovf_next  = status_reg[3] ? jump_to : pc + 21'h000002;
    assign zero_next = status_reg[2] ? jump_to : pc + 21'h000002;
    a_clear_zero_data: assert property (mem_write |-> mem_wdata == 8'h00 && zero_set
        && phase == 2'h3) else $error("clear write wrong");
    a_zero_set_source: assert property (zero_set |-> mem_write)
        else $error("zero flag set outside clear");
    a_push_return_addr: assert property (stack_push |-> stack_top == pc + 21'h000004
        && phase == 2'h3) else $error("return address wrong");
    a_call_pc_even: assert property (stack_push |=> pc[0] == 1'b0)
        else $error("call target odd");
    a_pc_q4_write: assert property (!$stable(pc) |-> $past(phase) == 2'h3)
        else $error("counter written off last phase");
    a_ovf_branch_target: assert property (phase == 2'h3 && instr_word[15:8] == 8'hE4
        && !busy |=> pc == $past(ovf_next)) else $error("overflow branch wrong");
    a_zero_branch_target: assert property (phase == 2'h3 && instr_word[15:8] == 8'hE0
        && !busy |=> pc == $past(zero_next)) else $error("zero branch wrong");
    a_shadow_on_call: assert property (!$stable(working_shadow) |-> stack_push)
        else $error("shadow changed outside call");
    a_wdt_flags_set: assert property (watchdog_clear |-> ##[0:1]
        (timeout_flag_n && powerdown_flag_n)) else $error("flags not set");
endmodule
bind bcc_exec bcc_exec_checker u_chk (.*);
`default_nettype wire

/* File: test_branch_call_clear_exec.sv */
// Random and corner-case bench for the execution unit
`timescale 1ns/100ps
`default_nettype none
module test_branch_call_clear_exec;
    import bcc_pkg::*;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [7:0]  working_reg = 8'h00;
    logic [7:0]  status_reg = 8'h00;
    logic [3:0]  bank_select_register = 4'h0;
    logic [11:0] index_base = 12'h000;
    logic        extended_enable = 1'b0;
    logic [20:0] pc;
    logic [20:0] stack_top;
    logic [1:0]  phase;
    logic        fetch_next, stack_push, mem_write, zero_set, watchdog_clear;
    logic        timeout_flag_n, powerdown_flag_n, busy;
    logic [7:0]  working_shadow, status_shadow, mem_wdata;
    logic [3:0]  bank_select_shadow;
    logic [11:0] mem_addr;
    int          err_total = 0;
    int          n_compared = 0;
    int          seed = 99;
    logic [20:0] exp_pc = 21'h000000;
    logic [19:0] exp_sh = 20'h00000;
    logic [20:0] q_top;
    logic [11:0] q_addr;
    logic [11:0] q_flags;
    logic        q_fetch;
    logic        q_busy;
    bcc_exec uut (.*);
    always #50 clk = ~clk;
    task chk(input logic [20:0] seen, input logic [20:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("errors %0d compares %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Q4 outputs are read at the closing edge, before it updates them
    task run(input logic [15:0] w, input logic [15:0] w2, input logic idle);
        instr_word <= w;
        @(posedge clk);
        chk(pc, exp_pc);
        chk(phase, 21'h0);
        repeat (2) @(posedge clk);
        instr_word <= w2;
        @(posedge clk);
        q_top = stack_top;
        q_addr = mem_addr;
        q_flags = {stack_push, mem_write, zero_set, watchdog_clear, mem_wdata};
        q_fetch = fetch_next;
        if (idle) begin
            instr_word <= 16'h0000;
            repeat (4) @(posedge clk);
        end
        q_busy = busy;
    endtask
    initial begin
        #200000;
        err_total++;
        close_out();
    end
    initial begin
        logic [31:0] r;
        logic [31:0] r2;
        logic [7:0]  n;
        logic        tk;
        logic [11:0] ea;
        int          kind;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 60; i++) begin
            r = $random(seed);
            r2 = $random(seed);
            kind = (i < 5) ? i : r2[30:28] % 5;
            n = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : r2[7:0];
            status_reg <= r[15:8];
            working_reg <= r[23:16];
            bank_select_register <= r[27:24];
            extended_enable <= r[31];
            index_base <= r2[27:16];
            if (kind < 2) begin
                tk = kind ? r[10] : r[11];
                run({kind ? 8'hE0 : 8'hE4, n}, {kind ? 8'hE0 : 8'hE4, n}, tk);
                exp_pc = exp_pc + 21'h000002 + (tk ? {{12{n[7]}}, n, 1'b0} : 21'h0);
                chk(q_busy, tk);
            end else if (kind == 2) begin
                run({7'h76, r2[20], n}, {4'hF, r2[19:8]}, 1'b1);
                chk(q_top, exp_pc + 21'h000004);
                chk(q_busy, 1'b1);
                if (r2[20])
                    exp_sh = {r[23:16], r[15:8], r[27:24]};
                chk({working_shadow, status_shadow, bank_select_shadow}, exp_sh);
                exp_pc = {r2[19:8], n, 1'b0};
            end else if (kind == 3) begin
                run({7'h35, r2[21], n}, {7'h35, r2[21], n}, 1'b0);
                ea = r2[21] ? {r[27:24], n} : {n < 8'h60 ? 4'h0 : 4'hF, n};
                if (!r2[21] && r[31] && n <= 8'h5F)
                    ea = r2[27:16] + {4'h0, n};
                chk(q_addr, ea);
                exp_pc = exp_pc + 21'h000002;
            end else begin
                run(16'h0004, 16'h0004, 1'b0);
                chk({q_flags[8], timeout_flag_n, powerdown_flag_n}, 3'h7);
                exp_pc = exp_pc + 21'h000002;
            end
            chk(q_flags[11], kind == 2);
            chk(q_fetch, kind == 2);
            chk(q_flags[10:0], kind == 3 ? 11'h600 : kind == 4 ? 11'h100 : 11'h000);
        end
        run(16'h0000, 16'h0000, 1'b0);
        close_out();
    end
endmodule
`default_nettype wire
